// ### cscm_pkg.sv
// constants, types and register map of the colour space matrix converter
`default_nettype none
package cscm_pkg;
    localparam int PLANE_W   = 8;
    localparam int COEF_W    = 16;
    localparam int ACC_W     = 28;
    localparam int FRAC_W    = 10;
    localparam real FRAC_SCALE = 1024.0;
    localparam int FIFO_W    = 3 * PLANE_W;
    localparam int FIFO_D    = 8;
    localparam int LVL_W     = 4;

    // wishbone word map, byte addresses
    localparam logic [7:0] ADR_CTRL   = 8'h00;
    localparam logic [7:0] ADR_STATUS = 8'h04;
    localparam logic [7:0] ADR_PIXCNT = 8'h08;

    // control field positions
    localparam int CTRL_DIR_BIT = 0;
    localparam int CTRL_SEQ_BIT = 1;
    localparam int CTRL_RND_LSB = 2;
    localparam int CTRL_SAT_BIT = 5;
    localparam logic [7:0] CTRL_RESET = 8'h20;

    // status field positions
    localparam int STAT_LVL_LSB  = 0;
    localparam int STAT_BUSY_BIT = 4;
    localparam int STAT_COL_LSB  = 5;

    typedef enum logic [2:0] {
        RND_NONE, RND_UP, RND_AWAY, RND_ZERO, RND_CONV
    } cscm_rnd_t;

    typedef struct packed {
        logic [PLANE_W-1:0] third;
        logic [PLANE_W-1:0] second;
        logic [PLANE_W-1:0] first;
    } cscm_pixel_t;

    typedef logic signed [COEF_W-1:0] cscm_coef_t;
    typedef logic signed [ACC_W-1:0]  cscm_acc_t;

    function automatic int cscm_q(input real r);
        return $rtoi(r * FRAC_SCALE + ((r < 0.0) ? -0.5 : 0.5));
    endfunction

    // row-major: row = output plane, column = input plane
    localparam cscm_coef_t TO_YCC_M [9] = '{
        COEF_W'(cscm_q(0.257)),  COEF_W'(cscm_q(0.504)),  COEF_W'(cscm_q(0.098)),
        COEF_W'(cscm_q(-0.148)), COEF_W'(cscm_q(-0.291)), COEF_W'(cscm_q(0.439)),
        COEF_W'(cscm_q(0.439)),  COEF_W'(cscm_q(-0.368)), COEF_W'(cscm_q(-0.071))};
    localparam cscm_acc_t TO_YCC_O [3] = '{
        ACC_W'(cscm_q(16.0)), ACC_W'(cscm_q(128.0)), ACC_W'(cscm_q(128.0))};
    localparam cscm_coef_t TO_RGB_M [9] = '{
        COEF_W'(cscm_q(1.164)), COEF_W'(cscm_q(0.0)),    COEF_W'(cscm_q(1.596)),
        COEF_W'(cscm_q(1.164)), COEF_W'(cscm_q(-0.392)), COEF_W'(cscm_q(-0.813)),
        COEF_W'(cscm_q(1.164)), COEF_W'(cscm_q(2.017)),  COEF_W'(cscm_q(0.0))};
    localparam cscm_acc_t TO_RGB_O [3] = '{
        ACC_W'(cscm_q(-222.912)), ACC_W'(cscm_q(135.616)), ACC_W'(cscm_q(-276.8))};
endpackage
`default_nettype wire

// ### cscm_top.sv
// colour space matrix converter: result fifo and converter top with wishbone registers
`timescale 1ns/1ns
`default_nettype none

module cscm_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 8
) (
    input  wire logic             core_clk_i,
    input  wire logic             rst_n_i,
    input  wire logic             clear_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o,
    output logic [$clog2(DEPTH):0] level_o
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_q, wr_d, rd_q, rd_d;
    logic [PW:0]      cnt_q, cnt_d;
    logic             push, pop;

    assign in_ready_o  = (cnt_q != (PW+1)'(DEPTH));
    assign out_valid_o = (cnt_q != '0);
    assign out_data_o  = mem[rd_q];
    assign level_o     = cnt_q;
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;

    always_comb
    begin
        wr_d  = wr_q;
        rd_d  = rd_q;
        cnt_d = cnt_q;
        if (clear_i)
        begin
            wr_d  = '0;
            rd_d  = '0;
            cnt_d = '0;
        end
        else
        begin
            if (push)
                wr_d = (wr_q == PW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
            if (pop)
                rd_d = (rd_q == PW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
            cnt_d = cnt_q + (PW+1)'(push) - (PW+1)'(pop);
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end
        else
        begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    // storage carries no reset; entries only read after being written
    always_ff @(posedge core_clk_i)
    begin
        if (push && !clear_i)
            mem[wr_q] <= in_data_i;
    end
endmodule

// Function
// - In the parallel mode all three results leave together with output-valid.
// - In the sequential mode results leave on the first port, valid on the first plane.
// - Luma is 0.257 R + 0.504 G + 0.098 B + 16.
// - Blue difference is -0.148 R - 0.291 G + 0.439 B + 128.
// - Red difference is 0.439 R - 0.368 G - 0.071 B + 128.
// - Red is 1.164 Y + 1.596 Cr - 222.912.
// - Green is 1.164 Y - 0.392 Cb - 0.813 Cr + 135.616.
// - Blue is 1.164 Y + 2.017 Cb - 276.8.
// - The pipeline moves only in cycles where clock enable is high.
// - The synchronous clear empties the pipeline state at a clock edge.
// - Convergent rounding sends an exact half to the nearest even value.
// - Saturation clamps an out-of-range result to the largest or smallest output.
module cscm_top (
    input  wire logic                    core_clk_i,
    input  wire logic                    rst_n_i,
    input  wire logic                    ce_i,
    input  wire logic                    sync_clear_i,
    input  wire logic                    wb_cyc_i,
    input  wire logic                    wb_stb_i,
    input  wire logic                    wb_we_i,
    input  wire logic [7:0]              wb_adr_i,
    input  wire logic [3:0]              wb_sel_i,
    input  wire logic [31:0]             wb_dat_i,
    output logic [31:0]                  wb_dat_o,
    output logic                         wb_ack_o,
    input  wire logic                    in_valid_i,
    output logic                         in_ready_o,
    input  wire logic [cscm_pkg::PLANE_W-1:0] in_plane_first_i,
    input  wire logic [cscm_pkg::PLANE_W-1:0] in_plane_second_i,
    input  wire logic [cscm_pkg::PLANE_W-1:0] in_plane_third_i,
    output logic                         out_valid_o,
    input  wire logic                    out_ready_i,
    output logic [cscm_pkg::PLANE_W-1:0] out_plane_first_o,
    output logic [cscm_pkg::PLANE_W-1:0] out_plane_second_o,
    output logic [cscm_pkg::PLANE_W-1:0] out_plane_third_o
);
    import cscm_pkg::*;

    // register bus state
    logic [7:0]  ctrl_q, ctrl_d;
    logic        ack_q, ack_d;
    logic [31:0] rdat_q, rdat_d;
    logic [31:0] pixcnt_q, pixcnt_d;

    // pipeline state
    logic [1:0]         col_q, col_d;
    logic [PLANE_W-1:0] hold0_q, hold0_d, hold1_q, hold1_d;
    cscm_pixel_t        s1_q, s1_d, s3_q, s3_d;
    logic               v1_q, v1_d, v2_q, v2_d, v3_q, v3_d;
    cscm_acc_t          s2_q [3];
    cscm_acc_t          s2_d [3];

    // output serialiser state
    cscm_pixel_t        ob_q, ob_d;
    logic [1:0]         ph_q, ph_d;
    logic               ov_q, ov_d;

    logic               dir_rgb, seq_mode, sat_on, adv;
    cscm_rnd_t          rnd;
    logic               f_in_ready, f_out_valid, f_pop;
    logic               take_first, load_ok;
    logic [FIFO_W-1:0]  f_out_data;
    logic [LVL_W-1:0]   f_level;
    logic [2:0][PLANE_W-1:0] s1_arr;
    logic [PLANE_W-1:0]      s3_arr [3];

    assign dir_rgb  = ctrl_q[CTRL_DIR_BIT];
    assign seq_mode = ctrl_q[CTRL_SEQ_BIT];
    assign sat_on   = ctrl_q[CTRL_SAT_BIT];
    assign rnd      = cscm_rnd_t'(ctrl_q[CTRL_RND_LSB +: 3]);

    // a full result fifo freezes the pipeline once stage 3 holds a valid result, rather than dropping pixels
    assign adv        = ce_i & (~v3_q | f_in_ready);
    assign in_ready_o = adv;
    assign s1_arr     = s1_q;

    // wishbone slave: one wait state, ack drops after one cycle
    always_comb
    begin
        ctrl_d = ctrl_q;
        ack_d  = wb_cyc_i & wb_stb_i & ~ack_q;
        rdat_d = rdat_q;
        if (ack_d)
        begin
            rdat_d = 32'h0;
            if (wb_we_i && wb_adr_i == ADR_CTRL && wb_sel_i[0])
                ctrl_d = wb_dat_i[7:0];
            else if (!wb_we_i)
            begin
                unique case (wb_adr_i)
                    ADR_CTRL:   rdat_d = {24'h0, ctrl_q};
                    ADR_STATUS: rdat_d = {25'h0, col_q, v1_q | v2_q | v3_q | ov_q,
                                          f_level};
                    ADR_PIXCNT: rdat_d = pixcnt_q;
                    default:    rdat_d = 32'h0;
                endcase
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ctrl_q <= CTRL_RESET;
            ack_q  <= 1'b0;
            rdat_q <= 32'h0;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            ack_q  <= ack_d;
            rdat_q <= rdat_d;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

    // input stage: parallel takes a pixel, sequential gathers three planes
    always_comb
    begin
        col_d   = col_q;
        hold0_d = hold0_q;
        hold1_d = hold1_q;
        s1_d    = s1_q;
        v1_d    = v1_q;
        if (sync_clear_i)
        begin
            col_d = 2'h0;
            v1_d  = 1'b0;
        end
        else if (adv)
        begin
            v1_d = 1'b0;
            if (!seq_mode)
            begin
                s1_d = '{third: in_plane_third_i, second: in_plane_second_i,
                         first: in_plane_first_i};
                v1_d = in_valid_i;
            end
            else
            begin
                unique case (col_q)
                    2'h0:
                    begin
                        hold0_d = in_plane_first_i;
                        if (in_valid_i)
                            col_d = 2'h1;
                    end
                    2'h1:
                    begin
                        hold1_d = in_plane_first_i;
                        col_d   = 2'h2;
                    end
                    default:
                    begin
                        s1_d  = '{third: in_plane_first_i, second: hold1_q, first: hold0_q};
                        v1_d  = 1'b1;
                        col_d = 2'h0;
                    end
                endcase
            end
        end
    end

    // matrix stage, one generate per output plane
    generate
        for (genvar p = 0; p < 3; p++)
        begin : g_row
            always_comb
            begin
                cscm_acc_t acc;
                acc = dir_rgb ? TO_RGB_O[p] : TO_YCC_O[p];
                for (int k = 0; k < 3; k++)
                begin
                    acc = acc + ACC_W'(signed'({1'b0, s1_arr[k]}))
                              * ACC_W'(dir_rgb ? TO_RGB_M[p*3+k]
                                               : TO_YCC_M[p*3+k]);
                end
                s2_d[p] = adv ? acc : s2_q[p];
            end

            // rounding and range stage
            always_comb
            begin
                cscm_acc_t   whole;
                cscm_acc_t   res;
                logic [FRAC_W-1:0] frac;
                logic        half, above, inc, neg;
                whole = s2_q[p] >>> FRAC_W;
                frac  = s2_q[p][FRAC_W-1:0];
                neg   = s2_q[p][ACC_W-1];
                half  = (frac == {1'b1, {(FRAC_W-1){1'b0}}});
                above = frac[FRAC_W-1] & ~half;
                unique case (rnd)
                    RND_UP:   inc = frac[FRAC_W-1];
                    RND_AWAY: inc = above | (half & ~neg);
                    RND_ZERO: inc = above | (half & neg);
                    RND_CONV: inc = above | (half & whole[0]);
                    default:  inc = 1'b0;
                endcase
                res = whole + ACC_W'(inc);
                if (sat_on && res < 0)
                    s3_arr[p] = '0;
                else if (sat_on && res > ACC_W'(2**PLANE_W - 1))
                    s3_arr[p] = '1;
                else
                    s3_arr[p] = res[PLANE_W-1:0];
            end
        end
    endgenerate

    always_comb
    begin
        v2_d = v2_q;
        v3_d = v3_q;
        s3_d = s3_q;
        if (sync_clear_i)
        begin
            v2_d = 1'b0;
            v3_d = 1'b0;
        end
        else if (adv)
        begin
            v2_d = v1_q;
            v3_d = v2_q;
            s3_d = '{third: s3_arr[2], second: s3_arr[1], first: s3_arr[0]};
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            col_q   <= 2'h0;
            hold0_q <= '0;
            hold1_q <= '0;
            s1_q    <= '0;
            s3_q    <= '0;
            v1_q    <= 1'b0;
            v2_q    <= 1'b0;
            v3_q    <= 1'b0;
            for (int i = 0; i < 3; i++)
                s2_q[i] <= '0;
        end
        else
        begin
            col_q   <= col_d;
            hold0_q <= hold0_d;
            hold1_q <= hold1_d;
            s1_q    <= s1_d;
            s3_q    <= s3_d;
            v1_q    <= v1_d;
            v2_q    <= v2_d;
            v3_q    <= v3_d;
            for (int i = 0; i < 3; i++)
                s2_q[i] <= s2_d[i];
        end
    end

    cscm_fifo #(
        .WIDTH (FIFO_W),
        .DEPTH (FIFO_D)
    ) u_fifo (
        .core_clk_i  (core_clk_i),
        .rst_n_i     (rst_n_i),
        .clear_i     (sync_clear_i),
        .in_valid_i  (v3_q & ce_i),
        .in_ready_o  (f_in_ready),
        .in_data_i   (s3_q),
        .out_valid_o (f_out_valid),
        .out_ready_i (f_pop),
        .out_data_o  (f_out_data),
        .level_o     (f_level)
    );

    // output: one pixel per beat, or three planes on the first port
    // first plane waits for out_ready; next pixel loads as the third plane leaves
    assign take_first = seq_mode & ov_q & out_ready_i & (ph_q == 2'h0);
    assign load_ok    = (ph_q == 2'h2) | ((ph_q == 2'h0) & (~ov_q | (out_ready_i & ~seq_mode)));
    assign f_pop      = ce_i & ~sync_clear_i & load_ok;

    always_comb
    begin
        ob_d     = ob_q;
        ph_d     = ph_q;
        ov_d     = ov_q;
        pixcnt_d = pixcnt_q;
        if (sync_clear_i)
        begin
            ph_d = 2'h0;
            ov_d = 1'b0;
        end
        else if (ce_i)
        begin
            if (take_first || ph_q == 2'h1)
            begin
                // later planes are committed once the first was taken
                ov_d       = 1'b0;
                ob_d.first = take_first ? ob_q.second : ob_q.third;
                ph_d       = take_first ? 2'h1 : 2'h2;
            end
            else if (load_ok)
            begin
                ov_d = f_out_valid;
                ph_d = 2'h0;
                if (f_out_valid)
                begin
                    ob_d     = f_out_data;
                    pixcnt_d = pixcnt_q + 32'h1;
                end
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ob_q     <= '0;
            ph_q     <= 2'h0;
            ov_q     <= 1'b0;
            pixcnt_q <= 32'h0;
        end
        else
        begin
            ob_q     <= ob_d;
            ph_q     <= ph_d;
            ov_q     <= ov_d;
            pixcnt_q <= pixcnt_d;
        end
    end

    assign out_valid_o        = ov_q;
    assign out_plane_first_o  = ob_q.first;
    assign out_plane_second_o = ob_q.second;
    assign out_plane_third_o  = ob_q.third;
endmodule
`default_nettype wire

// ### cscm_sva.sv
// checker on the converter top ports
`timescale 1ns/1ns
`default_nettype none
module cscm_sva (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic sync_clear_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic in_valid_i,
    input wire logic in_ready_o,
    input wire logic out_valid_o,
    input wire logic out_ready_i,
    input wire logic [cscm_pkg::PLANE_W-1:0] out_plane_first_o
);
    import cscm_pkg::*;
    logic [4:0] pend_q, pend_d;
    logic [3:0] wait_q, wait_d;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    // pixels in flight, so an output can be tied to an earlier input
    always_comb
    begin
        pend_d = pend_q + 5'(in_valid_i && in_ready_o) - 5'(out_valid_o && out_ready_i && ce_i);
        if (sync_clear_i)
            pend_d = '0;
        wait_d = (out_valid_o || pend_q == '0) ? '0 : wait_q + 4'(ce_i);
    end
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            pend_q <= '0;
            wait_q <= '0;
        end
        else
        begin
            pend_q <= pend_d;
            wait_q <= wait_d;
        end
    end
    sequence s_quiet3;
        !out_valid_o [*3];
    endsequence
    property p_ack_next;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    property p_ce_block;
        !ce_i |-> !in_ready_o;
    endproperty
    property p_ce_freeze;
        !ce_i && !sync_clear_i |=> $stable(out_valid_o) && $stable(out_plane_first_o);
    endproperty
    property p_clear;
        sync_clear_i |=> !out_valid_o;
    endproperty
    property p_hold;
        out_valid_o && !out_ready_i && !sync_clear_i |=> out_valid_o && $stable(out_plane_first_o);
    endproperty
    property p_no_phantom;
        out_valid_o |-> pend_q != 5'h00;
    endproperty
    property p_min_lat;
        in_valid_i && in_ready_o && pend_q == 5'h00 |=> s_quiet3;
    endproperty
    property p_max_wait;
        wait_q < 4'h9;
    endproperty
    a_ack_next: assert property (p_ack_next) else $error("ack late");
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    a_ce_block: assert property (p_ce_block) else $error("ready without enable");
    a_ce_freeze: assert property (p_ce_freeze) else $error("moved without enable");
    a_clear: assert property (p_clear) else $error("valid after clear");
    a_hold: assert property (p_hold) else $error("output dropped while stalled");
    a_no_phantom: assert property (p_no_phantom) else $error("output without input");
    a_min_lat: assert property (p_min_lat) else $error("output too early");
    a_max_wait: assert property (p_max_wait) else $error("output too late");
endmodule
bind cscm_top cscm_sva u_cscm_sva (.core_clk_i, .rst_n_i, .ce_i, .sync_clear_i, .wb_cyc_i,
    .wb_stb_i, .wb_ack_o, .in_valid_i, .in_ready_o, .out_valid_o, .out_ready_i,
    .out_plane_first_o);
`default_nettype wire

// ### cscm_sink_model.sv
// downstream sink: collects converted pixels, stalls on request
`timescale 1ns/1ns
`default_nettype none
module cscm_sink_model (
    input wire logic core_clk_i,
    input wire logic ce_i,
    input wire logic seq_i,
    input wire logic stall_i,
    input wire logic valid_i,
    input wire cscm_pkg::cscm_pixel_t pix_i,
    output logic ready_o
);
    import cscm_pkg::*;
    cscm_pixel_t got[$];
    cscm_pixel_t cur = '0;
    int left = 0;
    assign ready_o = !stall_i;
    // later planes stand one cycle only, so no handshake on them
    always @(posedge core_clk_i)
    begin
        if (ce_i && left > 0)
        begin
            cur[8*(3-left) +: 8] = pix_i.first;
            left--;
            if (left == 0)
                got.push_back(cur);
        end
        else if (ce_i && valid_i && ready_o)
        begin
            cur = pix_i;
            left = seq_i ? 2 : 0;
            if (!seq_i)
                got.push_back(cur);
        end
    end
endmodule
`default_nettype wire

// ### cscm_tb_top.sv
// self-checking bench for the colour space matrix converter
`timescale 1ns/1ns
`default_nettype none
module cscm_tb_top;
    import cscm_pkg::*;
    logic core_clk_i = 1'b0, rst_n_i = 1'b0, ce_i = 1'b1, sync_clear_i = 1'b0;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o, in_ready_o;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, r;
    logic in_valid_i = 1'b0, out_valid_o, out_ready_i, stall_i = 1'b0, hold_all = 1'b0;
    logic jitter = 1'b0, ce_jit = 1'b0, seq = 1'b0, dir = 1'b0, sat = 1'b1;
    logic [2:0] rnd = 3'h0;
    logic [7:0] tick = 8'h00;
    cscm_pixel_t pin = '0, pout, exp_q[$];
    int n_fail = 0, checks = 0;
    real cf [2][9] = '{'{0.257, 0.504, 0.098, -0.148, -0.291, 0.439, 0.439, -0.368, -0.071},
        '{1.164, 0.0, 1.596, 1.164, -0.392, -0.813, 1.164, 2.017, 0.0}};
    real off [2][3] = '{'{16.0, 128.0, 128.0}, '{-222.912, 135.616, -276.8}};
    // last two land on an exact half: luma forward, a negative red backward
    cscm_pixel_t px [8] = '{24'h000000, 24'hffffff, 24'h0000ff, 24'hff0000, 24'h801080,
        24'h10f0eb, 24'h800000, 24'h1b0002};

    cscm_top u_cscm_top (.core_clk_i, .rst_n_i, .ce_i, .sync_clear_i, .wb_cyc_i, .wb_stb_i,
        .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .in_valid_i,
        .in_ready_o, .in_plane_first_i(pin.first), .in_plane_second_i(pin.second),
        .in_plane_third_i(pin.third), .out_valid_o, .out_ready_i,
        .out_plane_first_o(pout.first), .out_plane_second_o(pout.second),
        .out_plane_third_o(pout.third));
    cscm_sink_model u_cscm_sink_model (.core_clk_i, .ce_i, .seq_i(seq), .stall_i,
        .valid_i(out_valid_o), .pix_i(pout), .ready_o(out_ready_i));

    always #25 core_clk_i = ~core_clk_i;
    always @(posedge core_clk_i)
    begin
        tick <= tick + 8'h01;
        ce_i <= !(ce_jit && tick % 3 == 0);
        stall_i <= hold_all || (jitter && tick[1]);
    end

    function automatic int q(input real v);
        return $rtoi(v * 1024.0 + ((v < 0.0) ? -0.5 : 0.5));
    endfunction
    function automatic cscm_pixel_t model(input cscm_pixel_t p);
        int s, v;
        cscm_pixel_t o;
        for (int j = 0; j < 3; j++)
        begin
            s = q(off[dir][j]);
            for (int k = 0; k < 3; k++)
                s += q(cf[dir][3*j+k]) * int'(p[8*k +: 8]);
            v = (s >>> 10) + int'(rnd inside {[1:4]} && (s[9:0] > 512 || s[9:0] == 512 &&
                ((rnd == 4) ? s[10] : (rnd == 1 || (rnd == 2) == (s > 0)))));
            o[8*j +: 8] = !sat ? v[7:0] : (v < 0) ? 8'h00 : (v > 255) ? 8'hff : v[7:0];
        end
        return o;
    endfunction

    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= wd;
        do @(posedge core_clk_i); while (wb_ack_o !== 1'b1);
        r = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge core_clk_i);
    endtask
    task automatic rdchk(input logic [7:0] adr, input logic [31:0] exp, input string what);
        wb(1'b0, adr, 32'h0);
        cmp(what, exp, r);
    endtask
    task automatic push(input cscm_pixel_t p);
        for (int k = 0; k < (seq ? 3 : 1); k++)
        begin
            in_valid_i <= (k == 0);
            pin <= seq ? {p.first, p.third, p[8*k +: 8]} : p;
            do @(posedge core_clk_i); while (in_ready_o !== 1'b1);
        end
        exp_q.push_back(model(p));
    endtask
    task automatic idle();
        in_valid_i <= 1'b0;
        pin <= ~pin;
        @(posedge core_clk_i);
    endtask
    task automatic drain();
        cscm_pixel_t g;
        for (int w = 0; w < 600 && u_cscm_sink_model.got.size() < exp_q.size(); w++)
            @(posedge core_clk_i);
        cmp("count", 32'(exp_q.size()), 32'(u_cscm_sink_model.got.size()));
        while (exp_q.size() > 0 && u_cscm_sink_model.got.size() > 0)
        begin
            g = u_cscm_sink_model.got.pop_front();
            cmp("pixel", 32'(exp_q.pop_front()), 32'(g));
        end
    endtask
    task automatic setc(input logic [5:0] c);
        {sat, rnd, seq, dir} = c;
        wb(1'b1, ADR_CTRL, {26'h0, c});
        rdchk(ADR_CTRL, {26'h0, c}, "ctrl");
    endtask
    task automatic final_report();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial
    begin
        repeat (4) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        @(posedge core_clk_i);
        rdchk(ADR_CTRL, 32'h20, "ctrl reset");
        wb(1'b1, 8'h0c, 32'hffff_ffff);
        rdchk(8'h0c, 32'h0, "unmapped");
        for (int m = 0; m < 40; m++)
        begin
            setc({m[2], m[5:3], m[1:0]});
            jitter <= m[1] ^ m[3];
            ce_jit <= m[0] ^ m[2];
            foreach (px[i])
                push(px[i]);
            idle();
            drain();
        end
        jitter <= 1'b0;
        ce_jit <= 1'b0;
        setc(6'h20);
        hold_all <= 1'b1;
        fork
            for (int i = 0; i < 14; i++)
                push(px[i % 7]);
            begin
                repeat (60) @(posedge core_clk_i);
                wb(1'b0, ADR_STATUS, 32'h0);
                cmp("fifo level full", 32'h8, r & 32'hf);
                @(negedge core_clk_i);
                cmp("ready when full", 32'h0, 32'(in_ready_o));
                @(posedge core_clk_i);
                hold_all <= 1'b0;
            end
        join
        idle();
        drain();
        hold_all <= 1'b1;
        for (int i = 0; i < 3; i++)
            push(px[i]);
        idle();
        repeat (10) @(posedge core_clk_i);
        sync_clear_i <= 1'b1;
        @(posedge core_clk_i);
        sync_clear_i <= 1'b0;
        hold_all <= 1'b0;
        exp_q.delete();
        @(negedge core_clk_i);
        cmp("valid after clear", 32'h0, 32'(out_valid_o));
        @(posedge core_clk_i);
        rdchk(ADR_STATUS, 32'h0, "status after clear");
        push(px[5]);
        idle();
        drain();
        final_report();
    end
    initial
    begin
        repeat (60000) @(posedge core_clk_i);
        n_fail++;
        final_report();
    end
endmodule
`default_nettype wire
